// ===== bench/ps_pmem_model.sv
// far side of the sequencer: program memory, instruction decoder, interrupt controller
// assumes the sequencer samples pmem_data, dec and int_req at the phase-four edge
`timescale 1ns/1ps
`default_nettype none

module ps_pmem_model #(
  parameter logic [ps_pkg::PC_W-1:0] VECTOR = 12'h300
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // program memory
  input wire logic [ps_pkg::PC_W-1:0] pmem_addr,
  output logic [ps_pkg::IW-1:0] pmem_data,
  // decoder
  input wire logic [ps_pkg::IW-1:0] ir,
  output var ps_pkg::ps_dec_t dec,
  // interrupt controller
  input wire logic irq_set,
  input wire logic int_ack,
  output logic int_req,
  output logic [ps_pkg::PC_W-1:0] int_vector
);
  logic [ps_pkg::IW-1:0] mem [0:4095];

  // ----------------------------------------
  // test program: kind[15:13] flag[12] target[11:0]
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 16'h0000;
    mem[0] = 16'h1705;
    mem[1] = 16'h10ff;
    mem[2] = 16'h4100;
    mem[3] = 16'h2200;
    mem[12'h100] = 16'hb000;
    mem[12'h101] = 16'h17ee;
    mem[12'h102] = 16'h6000;
    // nine nested calls overflow an eight-deep stack
    for (int k = 0; k < 9; k++) mem[12'h200 + k * 16] = 16'(16'h4210 + k * 16);
    for (int k = 2; k < 8; k++) mem[12'h201 + k * 16] = 16'h6000;
    mem[12'h290] = 16'h6000;
    mem[12'h282] = 16'h6000;
    mem[12'h211] = 16'h23f0;
    mem[12'h300] = 16'h8000;
    mem[12'h3f0] = 16'h23f0;
    mem[12'h355] = 16'h2355;
  end

  assign pmem_data = mem[pmem_addr];
  assign int_vector = VECTOR;

  always_comb begin
    dec.kind = ps_pkg::ps_kind_t'(ir[15:13]);
    dec.skip_met = ir[12];
    dec.target = ir[11:0];
    dec.alu_en = (ir[15:13] == 3'h0) && ir[12];
    dec.alu_op = ps_pkg::ps_alu_op_t'(ir[10:8]);
    dec.operand = ir[7:0];
  end

  // request stays recorded until acknowledged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_req <= 1'b0;
    end else if (irq_set) begin
      int_req <= 1'b1;
    end else if (int_ack) begin
      int_req <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== bench/test_program_sequencer.sv
// self-checking bench for the program sequencer
// assumes the memory model program; samples outputs at rising edges
`timescale 1ns/1ps
`default_nettype none

module test_program_sequencer;
  logic CLK, RST_N, INT_REQ, INT_ACK, IR_VALID, AVS_WAITREQUEST, irq_set;
  ps_pkg::ps_avs_req_t req;
  ps_pkg::ps_dec_t DEC;
  logic [31:0] AVS_READDATA, q;
  logic [11:0] PMEM_ADDR, INT_VECTOR;
  logic [15:0] PMEM_DATA, IR;
  logic [3:0] PHASE_CLOCKS;
  logic [7:0] ACC;
  logic seen_281, seen_201;
  int n_fail, samples_checked, n;

  ps_sequencer ps_sequencer_i (.CLK(CLK), .RST_N(RST_N), .AVS_REQ(req),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PMEM_ADDR(PMEM_ADDR),
    .PMEM_DATA(PMEM_DATA), .IR(IR), .IR_VALID(IR_VALID), .DEC(DEC), .INT_REQ(INT_REQ),
    .INT_VECTOR(INT_VECTOR), .INT_ACK(INT_ACK), .PHASE_CLOCKS(PHASE_CLOCKS), .ACC(ACC));
  ps_pmem_model ps_pmem_model_i (.clk(CLK), .rst_n(RST_N), .pmem_addr(PMEM_ADDR),
    .pmem_data(PMEM_DATA), .ir(IR), .dec(DEC), .irq_set(irq_set), .int_ack(INT_ACK),
    .int_req(INT_REQ), .int_vector(INT_VECTOR));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  // visit flags for the stack scenario
  always @(posedge CLK) begin
    if (PMEM_ADDR === 12'h281) seen_281 <= 1'b1;
    if (PMEM_ADDR === 12'h201) seen_201 <= 1'b1;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // counts edges until the fetch address shows a
  task automatic wait_addr(input logic [11:0] a, output int c);
    c = 0;
    do begin
      @(posedge CLK);
      c++;
    end while (PMEM_ADDR !== a && c < 3000);
    chk("fetch_address", {20'h0, a}, {20'h0, PMEM_ADDR});
    if (c >= 3000) stop_test();
  endtask

  // held until waitrequest is sampled low; no fixed latency assumed
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int c;
    c = 0;
    req.address <= a;
    req.read <= !wr;
    req.write <= wr;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    do begin
      @(posedge CLK);
      c++;
    end while (AVS_WAITREQUEST !== 1'b0 && c < 50);
    rd = AVS_READDATA;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (c >= 50) begin
      chk("waitrequest", 32'h0, 32'h1);
      stop_test();
    end
    // idle edge so the next call never reassigns the strobes in this time step
    @(posedge CLK);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    RST_N = 1'b0;
    req = '0;
    irq_set = 1'b0;
    seen_281 = 1'b0;
    seen_201 = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (10) @(posedge CLK);
    chk("phase_reset", 32'h1, {28'h0, PHASE_CLOCKS});
    chk("pc_reset", 32'h0, {20'h0, PMEM_ADDR});
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    wait_addr(12'h001, n);
    wait_addr(12'h002, n);
    chk("plain_step", 32'd4, n);
    wait_addr(12'h100, n);
    chk("call_cycles", 32'd8, n);
    chk("call_flush", 32'h0, {31'h0, IR_VALID});
    wait_addr(12'h003, n);
    chk("acc_after_skip", 32'h4, {24'h0, ACC});
    wait_addr(12'h290, n);
    // descent fetched both addresses already; only later visits count
    seen_281 <= 1'b0;
    seen_201 <= 1'b0;
    irq_set <= 1'b1;
    @(posedge CLK);
    irq_set <= 1'b0;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (INT_ACK !== 1'b1 && n < 200);
    chk("int_ack", 32'h1, {31'h0, INT_ACK});
    chk("ack_after_pop", 32'h1, {31'h0, seen_281});
    wait_addr(12'h300, n);
    wait_addr(12'h211, n);
    chk("oldest_lost", 32'h0, {31'h0, seen_201});
    wait_addr(12'h3f0, n);
    bus(1'b0, ps_pkg::OFS_PC_LOW_BYTE, 32'h0, q);
    chk("pc_low_read", 32'h0000_00f0, q);
    bus(1'b1, ps_pkg::OFS_STATUS, 32'hffff_ffff, q);
    bus(1'b0, ps_pkg::OFS_STATUS, 32'h0, q);
    chk("status_carry", 32'h1, {31'h0, q[ps_pkg::ST_CARRY]});
    chk("status_acc", 32'h4, {24'h0, q[7:0]});
    bus(1'b0, 4'h8, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, ps_pkg::OFS_PC_LOW_BYTE, 32'h0000_0055, q);
    wait_addr(12'h355, n);
    chk("pc_write_dummy", 32'h0, {31'h0, IR_VALID});
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("pc_rereset", 32'h0, {20'h0, PMEM_ADDR});
    chk("ir_rereset", 32'h0, {31'h0, IR_VALID});
    RST_N <= 1'b1;
    n = 0;
    while (PHASE_CLOCKS !== 4'h2 && n < 20) begin
      @(posedge CLK);
      n++;
    end
    for (int i = 1; i < 5; i++) begin
      chk("phase_rotate", 32'(1 << (i % 4)), {28'h0, PHASE_CLOCKS});
      @(posedge CLK);
    end
    wait_addr(12'h001, n);
    stop_test();
  end
endmodule

`default_nettype wire

// ===== pkg/ps_pkg.sv
// program sequencer package: sizes, register map, status fields and carriers
// assumes a single 50 MHz clock domain shared by all users of these types
package ps_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int PC_W = 12;
  localparam int IW = 16;
  localparam int DW = 8;
  localparam int STACK_DEPTH = 8;
  localparam int PAGE_W = 8;
  localparam int NPHASE = 4;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 4;

  // ----------------------------------------
  // reset values and register map
  // ----------------------------------------
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [NPHASE-1:0] PHASE_RST = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PC_LOW_BYTE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

  // status word fields
  localparam int ST_ACC = 0;
  localparam int ST_CARRY = 8;
  localparam int ST_ZERO = 9;
  localparam int ST_IR_VALID = 10;
  localparam int ST_INT_BLOCKED = 11;
  localparam int ST_PC = 16;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef enum logic [2:0] {
    PS_K_SEQ = 3'h0,
    PS_K_BRANCH = 3'h1,
    PS_K_CALL = 3'h2,
    PS_K_RET = 3'h3,
    PS_K_INTERRUPT_RETURN = 3'h4,
    PS_K_SKIP = 3'h5
  } ps_kind_t;

  typedef enum logic [2:0] {
    PS_A_ADD = 3'h0,
    PS_A_ADC = 3'h1,
    PS_A_SUB = 3'h2,
    PS_A_SBC = 3'h3,
    PS_A_AND = 3'h4,
    PS_A_OR = 3'h5,
    PS_A_XOR = 3'h6,
    PS_A_MOV = 3'h7
  } ps_alu_op_t;

  typedef struct packed {
    ps_kind_t kind;
    logic skip_met;
    logic [PC_W-1:0] target;
    logic alu_en;
    ps_alu_op_t alu_op;
    logic [DW-1:0] operand;
  } ps_dec_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [BUS_W-1:0] writedata;
    logic [3:0] byteenable;
  } ps_avs_req_t;

endpackage

// ===== rtl/ps_sequencer.sv
// program sequencer: phase clocks, fetch/execute overlap, pc, return stack,
// accumulator alu, avalon-mm register slave
// assumes an outside decoder turns IR into DEC combinationally within the
// instruction cycle, and program memory returns PMEM_DATA for PMEM_ADDR
// before the edge that ends phase four
//
// Notes on behaviour
// (RL1) clock splits into four one-hot phases; four phases make one instruction cycle
// (RL2) pc advances entering phase one, fetch runs then; other phases execute
// (RL3) next fetch overlaps current execute, one plain instruction per cycle
// (RL4) jumps and calls take two cycles; the prefetched word is flushed
// (RL5) pc steps by one unless the instruction transfers control elsewhere
// (RL6) jump, call, interrupt entry and reset load the target into pc
// (RL7) taken skip discards the fetched word and runs a dummy cycle
// (RL8) pc low byte readable and writable; write jumps inside current 256-word page
// (RL9) pc low byte write inserts one dummy cycle for the prefetch
// (RL10) eight-level stack holds only pc values, hidden from software
// (RL11) call or interrupt acknowledge pushes the return pc
// (RL12) subroutine return or interrupt return pops the top into pc
// (RL13) reset leaves the stack empty, pointer at top
// (RL14) full stack blocks interrupt acknowledge until a return pops
// (RL15) call with full stack still proceeds and loses the oldest entry
// (RL16) alu writes result to accumulator and updates zero; only add, adc, sub and sbc update carry
// (RL17) pc addresses 4K words of 16 bits
// (RL18) execution starts at address zero after any reset
// (RL19) data path is 8 bits through accumulator and alu
// (RL20) overflow wraps pointer so newest overwrites oldest, eight kept
`timescale 1ns/1ps
`default_nettype none

module ps_sequencer #(
  parameter int STACK_DEPTH = ps_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // avalon-mm register slave
  input wire ps_pkg::ps_avs_req_t AVS_REQ,
  output logic [ps_pkg::BUS_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // program memory
  output logic [ps_pkg::PC_W-1:0] PMEM_ADDR,
  input wire logic [ps_pkg::IW-1:0] PMEM_DATA,
  // instruction to decoder and decoded control back
  output logic [ps_pkg::IW-1:0] IR,
  output logic IR_VALID,
  input wire ps_pkg::ps_dec_t DEC,
  // interrupt controller
  input wire logic INT_REQ,
  input wire logic [ps_pkg::PC_W-1:0] INT_VECTOR,
  output logic INT_ACK,
  // phase clocks and data path
  output logic [ps_pkg::NPHASE-1:0] PHASE_CLOCKS,
  output logic [ps_pkg::DW-1:0] ACC
);

  // ----------------------------------------
  // elaboration checks and local sizes
  // ----------------------------------------
  localparam int PTR_W = $clog2(STACK_DEPTH);
  localparam int CNT_W = $clog2(STACK_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(STACK_DEPTH);

  // pointer wrap relies on a power of two depth
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("STACK_DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [ps_pkg::NPHASE-1:0] phase;
    logic [ps_pkg::PC_W-1:0] pc;
    logic [ps_pkg::IW-1:0] ir;
    logic ir_vld;
    logic [STACK_DEPTH-1:0][ps_pkg::PC_W-1:0] stack;
    logic [PTR_W-1:0] top;
    logic [CNT_W-1:0] cnt;
    logic [ps_pkg::DW-1:0] acc;
    logic carry;
    logic zero;
    logic int_ack;
    logic int_blk;
    logic pcl_pend;
    logic [ps_pkg::PAGE_W-1:0] pcl_val;
    logic ack;
    logic [ps_pkg::BUS_W-1:0] rdata;
  } ps_state_t;

  ps_state_t s_q;
  ps_state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n_s;
  logic bnd;
  logic full;
  logic [ps_pkg::PC_W-1:0] top_val;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_s = rst_sync_q[1];
  assign bnd = s_q.phase[ps_pkg::NPHASE-1];
  assign full = (s_q.cnt == CNT_FULL);
  assign top_val = s_q.stack[PTR_W'(s_q.top - PTR_W'(1))];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [ps_pkg::PC_W-1:0] nxt_pc;
    logic nxt_vld;
    logic push;
    logic pop;
    logic take_int;
    logic [ps_pkg::DW:0] wide;
    logic [ps_pkg::DW:0] cin;
    ps_pkg::ps_kind_t kind;
    nxt_pc = '0;
    nxt_vld = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    take_int = 1'b0;
    wide = '0;
    cin = {{ps_pkg::DW{1'b0}}, s_q.carry};
    kind = s_q.ir_vld ? DEC.kind : ps_pkg::PS_K_SEQ;
    s_d = s_q;
    s_d.int_ack = 1'b0;
    s_d.ack = 1'b0;

    s_d.phase = {s_q.phase[ps_pkg::NPHASE-2:0], s_q.phase[ps_pkg::NPHASE-1]}; // RL1

    if (bnd) begin
      // default flow: next word already at pc, pc steps by one
      nxt_pc = s_q.pc + 1'b1; // RL2 RL5
      nxt_vld = 1'b1; // RL3
      case (kind)
        ps_pkg::PS_K_BRANCH: begin
          nxt_pc = DEC.target; // RL6
          nxt_vld = 1'b0; // RL4
        end
        ps_pkg::PS_K_CALL: begin
          push = 1'b1; // RL11
          nxt_pc = DEC.target; // RL6
          nxt_vld = 1'b0; // RL4
        end
        ps_pkg::PS_K_RET, ps_pkg::PS_K_INTERRUPT_RETURN: begin
          pop = 1'b1; // RL12
          nxt_pc = top_val;
          nxt_vld = 1'b0;
        end
        ps_pkg::PS_K_SKIP: begin
          if (DEC.skip_met) begin
            nxt_vld = 1'b0; // RL7
          end
        end
        default: begin
        end
      endcase

      // interrupt only between plain instructions and never with a full stack
      take_int = INT_REQ && !full && nxt_vld && !s_q.pcl_pend; // RL14
      s_d.int_blk = INT_REQ && full; // RL14
      if (take_int) begin
        push = 1'b1; // RL11
        nxt_pc = INT_VECTOR; // RL6
        nxt_vld = 1'b0;
        s_d.int_ack = 1'b1;
      end

      // a pending low byte write overrides this cycle's target
      if (s_q.pcl_pend) begin
        nxt_pc = {s_q.pc[ps_pkg::PC_W-1:ps_pkg::PAGE_W], s_q.pcl_val}; // RL8
        nxt_vld = 1'b0; // RL9
        s_d.pcl_pend = 1'b0;
      end

      if (push) begin
        s_d.stack[s_q.top] = s_q.pc; // RL10
        s_d.top = PTR_W'(s_q.top + PTR_W'(1)); // RL20
        if (!full) begin
          s_d.cnt = CNT_W'(s_q.cnt + CNT_W'(1));
        end
        // full: count stays, oldest slot just got overwritten
      end else if (pop) begin
        s_d.top = PTR_W'(s_q.top - PTR_W'(1));
        if (s_q.cnt != '0) begin
          s_d.cnt = CNT_W'(s_q.cnt - CNT_W'(1));
        end
      end

      if (s_q.ir_vld && DEC.alu_en) begin
        case (DEC.alu_op)
          ps_pkg::PS_A_ADD: wide = {1'b0, s_q.acc} + {1'b0, DEC.operand};
          ps_pkg::PS_A_ADC: wide = {1'b0, s_q.acc} + {1'b0, DEC.operand} + cin;
          ps_pkg::PS_A_SUB: wide = {1'b0, s_q.acc} - {1'b0, DEC.operand};
          ps_pkg::PS_A_SBC: wide = {1'b0, s_q.acc} - {1'b0, DEC.operand} - cin;
          ps_pkg::PS_A_AND: wide = {s_q.carry, s_q.acc & DEC.operand};
          ps_pkg::PS_A_OR: wide = {s_q.carry, s_q.acc | DEC.operand};
          ps_pkg::PS_A_XOR: wide = {s_q.carry, s_q.acc ^ DEC.operand};
          default: wide = {s_q.carry, DEC.operand};
        endcase
        s_d.acc = wide[ps_pkg::DW-1:0]; // RL16 RL19
        s_d.carry = wide[ps_pkg::DW]; // RL16
        s_d.zero = (wide[ps_pkg::DW-1:0] == '0); // RL16
      end

      s_d.pc = nxt_pc; // RL17
      s_d.ir = PMEM_DATA;
      s_d.ir_vld = nxt_vld;
    end

    // ----------------------------------------
    // register slave, one wait state
    // ----------------------------------------
    if ((AVS_REQ.read || AVS_REQ.write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = '0;
      if (AVS_REQ.address == ps_pkg::OFS_PC_LOW_BYTE) begin
        s_d.rdata[ps_pkg::PAGE_W-1:0] = s_q.pc[ps_pkg::PAGE_W-1:0]; // RL8
      end else if (AVS_REQ.address == ps_pkg::OFS_STATUS) begin
        s_d.rdata[ps_pkg::ST_ACC +: ps_pkg::DW] = s_q.acc;
        s_d.rdata[ps_pkg::ST_CARRY] = s_q.carry;
        s_d.rdata[ps_pkg::ST_ZERO] = s_q.zero;
        s_d.rdata[ps_pkg::ST_IR_VALID] = s_q.ir_vld;
        s_d.rdata[ps_pkg::ST_INT_BLOCKED] = s_q.int_blk;
        s_d.rdata[ps_pkg::ST_PC +: ps_pkg::PC_W] = s_q.pc;
      end
    end

    // placed after the boundary so a new write wins over the clear
    if (s_q.ack && AVS_REQ.write && AVS_REQ.byteenable[0]
        && AVS_REQ.address == ps_pkg::OFS_PC_LOW_BYTE) begin
      s_d.pcl_pend = 1'b1; // RL9
      s_d.pcl_val = AVS_REQ.writedata[ps_pkg::PAGE_W-1:0];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_q <= '0;
      s_q.phase <= ps_pkg::PHASE_RST;
      s_q.pc <= ps_pkg::RESET_VECTOR; // RL18 RL6
      s_q.cnt <= '0; // RL13
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = (AVS_REQ.read || AVS_REQ.write) && !s_q.ack;
  assign PMEM_ADDR = s_q.pc;
  assign IR = s_q.ir;
  assign IR_VALID = s_q.ir_vld;
  assign INT_ACK = s_q.int_ack;
  assign PHASE_CLOCKS = s_q.phase;
  assign ACC = s_q.acc;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n_s);

  AST_PHASE_ONEHOT: assert property ($onehot(s_q.phase)) // RL1
    else $error("phase clocks not one-hot");

  AST_PHASE_SEQ: assert property ( // RL1
    s_q.phase[0] |-> ##3 s_q.phase[3] ##1 s_q.phase[0])
    else $error("phase sequence broken");

  AST_PC_STILL: assert property (!bnd |=> $stable(s_q.pc)) // RL2
    else $error("pc moved outside phase boundary");

  AST_PC_STEP: assert property ( // RL5
    bnd && s_q.ir_vld && DEC.kind == ps_pkg::PS_K_SEQ && !s_q.pcl_pend && !INT_REQ
    |=> s_q.pc == $past(s_q.pc) + 1'b1 && s_q.ir_vld)
    else $error("pc did not step by one");

  AST_BRANCH: assert property ( // RL4
    bnd && s_q.ir_vld && DEC.kind == ps_pkg::PS_K_BRANCH && !s_q.pcl_pend
    |=> s_q.pc == $past(DEC.target) && !s_q.ir_vld)
    else $error("branch target or flush wrong");

  AST_SKIP: assert property ( // RL7
    bnd && s_q.ir_vld && DEC.kind == ps_pkg::PS_K_SKIP && DEC.skip_met && !s_q.pcl_pend
    |=> !s_q.ir_vld && s_q.pc == $past(s_q.pc) + 1'b1)
    else $error("taken skip did not discard");

  AST_PCL_JUMP: assert property ( // RL8
    bnd && s_q.pcl_pend
    |=> (s_q.pc >> ps_pkg::PAGE_W) == ($past(s_q.pc) >> ps_pkg::PAGE_W)
        && s_q.pc[ps_pkg::PAGE_W-1:0] == $past(s_q.pcl_val) && !s_q.ir_vld)
    else $error("low byte jump left page or no dummy");

  AST_INT_FULL: assert property (bnd && full |=> !s_q.int_ack) // RL14
    else $error("interrupt acknowledged with full stack");

  AST_RET_POP: assert property ( // RL12
    bnd && s_q.ir_vld && !s_q.pcl_pend
    && (DEC.kind == ps_pkg::PS_K_RET || DEC.kind == ps_pkg::PS_K_INTERRUPT_RETURN)
    |=> s_q.pc == $past(top_val))
    else $error("return did not restore pc");

  AST_CALL_PUSH: assert property ( // RL11
    bnd && s_q.ir_vld && DEC.kind == ps_pkg::PS_K_CALL && !full
    |=> s_q.cnt == $past(s_q.cnt) + 1'b1 && top_val == $past(s_q.pc))
    else $error("call did not push return pc");

  AST_CALL_OVF: assert property ( // RL15
    bnd && s_q.ir_vld && DEC.kind == ps_pkg::PS_K_CALL && full && !s_q.pcl_pend
    |=> full && top_val == $past(s_q.pc) && s_q.pc == $past(DEC.target))
    else $error("overflowing call misbehaved");

  AST_RESET_VEC: assert property ( // RL18
    $rose(rst_n_s) |-> s_q.pc == ps_pkg::RESET_VECTOR && s_q.cnt == '0)
    else $error("reset did not clear pc and stack");

  // an interrupt entry is one clock wide and lands on the vector with a dummy cycle
  AST_INT_ENTRY: assert property ( // RL6
    s_q.int_ack |-> s_q.pc == $past(INT_VECTOR) && !s_q.ir_vld)
    else $error("interrupt entry did not load vector");

  AST_INT_PULSE: assert property (s_q.int_ack |=> !s_q.int_ack) // RL11
    else $error("interrupt acknowledge longer than one clock");

  AST_STACK_LIMIT: assert property (s_q.cnt <= CNT_FULL) // RL10
    else $error("stack count above depth");

  AST_RET_CNT: assert property ( // RL12
    bnd && s_q.ir_vld && s_q.cnt != '0
    && (DEC.kind == ps_pkg::PS_K_RET || DEC.kind == ps_pkg::PS_K_INTERRUPT_RETURN)
    |=> s_q.cnt == $past(s_q.cnt) - 1'b1)
    else $error("return did not drop stack count");

  // the master holds its request, so exactly one wait state is seen
  AST_ONE_WAIT: assert property ( // RL8
    (AVS_REQ.read || AVS_REQ.write) && !s_q.ack |=> !AVS_WAITREQUEST)
    else $error("bus answer not after one wait state");

  AST_PCL_READ: assert property ( // RL8
    s_q.ack && AVS_REQ.read && AVS_REQ.address == ps_pkg::OFS_PC_LOW_BYTE
    |-> AVS_READDATA[ps_pkg::PAGE_W-1:0] == $past(s_q.pc[ps_pkg::PAGE_W-1:0]))
    else $error("low byte read does not show pc");

  COV_CALL: cover property (bnd && s_q.ir_vld && DEC.kind == ps_pkg::PS_K_CALL);
  COV_RET: cover property (bnd && s_q.ir_vld && DEC.kind == ps_pkg::PS_K_RET);
  COV_INT: cover property (s_q.int_ack);
  COV_PCL: cover property (bnd && s_q.pcl_pend);

endmodule

`default_nettype wire
